// ===== logic/irt_regs.svh
// Constants for the I2C register target port and its bus master controller.
`ifndef IRT_REGS_SVH
`define IRT_REGS_SVH

// ****************************************
// Target address and byte space
// ****************************************
`define IRT_DEFAULT_CODE     4'h1
`define IRT_VOUT_ADDR        11'h1DB
`define IRT_VOUT_RESET       8'h00
`define IRT_DIR_READ         1'b1
`define IRT_DIR_WRITE        1'b0
`define IRT_BYTE_BITS        4'h8

// ****************************************
// Controller register offsets
// ****************************************
`define IRT_OFS_CTRL         12'h000
`define IRT_OFS_CMD          12'h004
`define IRT_OFS_STATUS       12'h008
`define IRT_OFS_RDATA        12'h00C

// ****************************************
// Controller field positions and reset values
// ****************************************
`define IRT_CTRL_GO_BIT      0
`define IRT_CTRL_RD_BIT      1
`define IRT_CMD_CODE_LSB     0
`define IRT_CMD_BLK_LSB      4
`define IRT_CMD_WADDR_LSB    8
`define IRT_CMD_WDATA_LSB    16
`define IRT_CMD_RESET        24'h00_0000
`define IRT_STAT_BUSY_BIT    0
`define IRT_STAT_NACK_BIT    1
`define IRT_STAT_DONE_BIT    2

// ****************************************
// Timing
// ****************************************
`define IRT_PCLK_PERIOD_NS   20
`define IRT_SCL_PERIOD_NS    2000
`define IRT_QTR_CYCLES       ((`IRT_SCL_PERIOD_NS + 4 * `IRT_PCLK_PERIOD_NS - 1) / \
                              (4 * `IRT_PCLK_PERIOD_NS))

`endif

// ===== logic/irt_pkg.sv
// Types shared by both ends of the I2C register target link.
package irt_pkg;

  // States of the target's byte engine.
  typedef enum logic [2:0] {
    TS_IDLE, TS_CTRL, TS_WADDR, TS_WDATA, TS_ACK, TS_READ, TS_SKIP
  } irt_tgt_state_t;

  // Kinds of bus element the controller issues.
  typedef enum logic [1:0] {
    K_START, K_TX, K_RX, K_STOP
  } irt_kind_t;

  // States of the controller.
  typedef enum logic {
    HS_IDLE, HS_RUN
  } irt_hst_state_t;

endpackage : irt_pkg

// ===== logic/irt_link_if.sv
// Open-drain two-wire link joining the bus master controller and the target.
`timescale 1ns/100ps
`default_nettype none

interface irt_link_if (
  input wire logic link_clk
);
  logic m_scl_out;
  logic m_scl_oe_n;
  logic m_sda_out;
  logic m_sda_oe_n;
  logic t_sda_out;
  logic t_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND: a line is low while any enabled driver pulls it low.
  assign scl = ~(~m_scl_oe_n & ~m_scl_out);
  assign sda = ~((~m_sda_oe_n & ~m_sda_out) | (~t_sda_oe_n & ~t_sda_out));

  modport master (
    input  scl,
    input  sda,
    output m_scl_out,
    output m_scl_oe_n,
    output m_sda_out,
    output m_sda_oe_n
  );

  modport target (
    input  link_clk,
    input  scl,
    input  sda,
    output t_sda_out,
    output t_sda_oe_n
  );
endinterface : irt_link_if

`default_nettype wire

// ===== logic/irt_target.sv
// I2C register target port: control byte match, byte write, random read.
`timescale 1ns/100ps
`default_nettype none

`include "irt_regs.svh"

module irt_target
  import irt_pkg::*;
(
  input  wire logic       link_rst_n,
  input  wire logic [3:0] cfg_code,
  input  wire logic       cfg_addr_sel,
  output logic      [7:0] virtual_output_bits,
  irt_link_if.target      link
);

  // ****************************************
  // Declarations
  // ****************************************
  logic           scl_s1_reg;
  logic           scl_s2_reg;
  logic           scl_s3_reg;
  logic           sda_s1_reg;
  logic           sda_s2_reg;
  logic           sda_s3_reg;
  logic     [4:0] cfg_s1_reg;
  logic     [4:0] cfg_s2_reg;
  irt_tgt_state_t state_reg;
  irt_tgt_state_t after_ack_reg;
  logic     [7:0] shift_reg;
  logic     [3:0] cnt_reg;
  logic     [2:0] blk_reg;
  logic    [10:0] ptr_reg;
  logic     [7:0] tx_reg;
  logic           sda_oe_n_reg;
  logic     [7:0] vout_reg;

  wire            scl_rise;
  wire            scl_fall;
  wire            start_det;
  wire            stop_det;
  wire            rx_state;
  wire            byte_full;
  wire      [3:0] match_code;
  wire            ctrl_hit;
  wire      [7:0] rd_data;
  wire            vout_write;
  irt_tgt_state_t rx_next;

  // Decodes whether a byte address selects the virtual output byte.
  function automatic logic is_vout(input logic [10:0] addr);
    is_vout = (addr == `IRT_VOUT_ADDR);
  endfunction : is_vout

  // ****************************************
  // Line synchronisers
  // ****************************************

  // Two flops bring each line and the config into the link clock domain; a third gives edges.
  always_ff @(posedge link.link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      cfg_s1_reg <= 5'h00;
      cfg_s2_reg <= 5'h00;
    end else begin
      scl_s1_reg <= link.scl;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      cfg_s1_reg <= {cfg_addr_sel, cfg_code};
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  // ****************************************
  // Bus event and byte decode
  // ****************************************

  // Clock edges, and data edges while the clock stays high mark start and stop.
  assign scl_rise  = scl_s2_reg & ~scl_s3_reg;
  assign scl_fall  = ~scl_s2_reg & scl_s3_reg;
  assign start_det = scl_s2_reg & scl_s3_reg & ~sda_s2_reg & sda_s3_reg;
  assign stop_det  = scl_s2_reg & scl_s3_reg & sda_s2_reg & ~sda_s3_reg;

  // Receive states shift in eight bits; the ninth clock is the acknowledge slot.
  assign rx_state  = (state_reg == TS_CTRL) | (state_reg == TS_WADDR) |
                     (state_reg == TS_WDATA);
  assign byte_full = (cnt_reg == `IRT_BYTE_BITS);

  // The match value is either the programmed code or the fixed default code.
  assign match_code = cfg_s2_reg[4] ? cfg_s2_reg[3:0] : `IRT_DEFAULT_CODE;
  assign ctrl_hit   = (shift_reg[7:4] == match_code);

  // Direction bit decides between word address and read data after the ack.
  assign rx_next = (state_reg == TS_CTRL) ?
                     ((shift_reg[0] == `IRT_DIR_READ) ? TS_READ : TS_WADDR) :
                   (state_reg == TS_WADDR) ? TS_WDATA : TS_SKIP;

  // Only the virtual output byte is mapped; other addresses read as zero.
  assign rd_data = is_vout(ptr_reg) ? vout_reg : 8'h00;

  // The data byte lands at the same edge that starts driving its acknowledge.
  assign vout_write = scl_fall & byte_full & (state_reg == TS_WDATA) &
                      is_vout(ptr_reg) & ~start_det & ~stop_det;

  // ****************************************
  // Byte engine
  // ****************************************

  // Sequences control byte, word address, data and read bits on the bus.
  always_ff @(posedge link.link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_reg     <= TS_IDLE;
      after_ack_reg <= TS_IDLE;
      shift_reg     <= 8'h00;
      cnt_reg       <= 4'h0;
      tx_reg        <= 8'h00;
      sda_oe_n_reg  <= 1'b1;
    end else if (start_det) begin
      state_reg    <= TS_CTRL;
      cnt_reg      <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end else if (stop_det) begin
      state_reg    <= TS_IDLE;
      cnt_reg      <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end else if (rx_state) begin
      if (scl_rise && !byte_full) begin
        shift_reg <= {shift_reg[6:0], sda_s2_reg};
        cnt_reg   <= cnt_reg + 4'h1;
      end else if (scl_fall && byte_full) begin
        cnt_reg <= 4'h0;
        if ((state_reg == TS_CTRL) && !ctrl_hit) begin
          state_reg <= TS_SKIP;
        end else begin
          sda_oe_n_reg  <= 1'b0;
          state_reg     <= TS_ACK;
          after_ack_reg <= rx_next;
        end
      end
    end else if ((state_reg == TS_ACK) && scl_fall) begin
      if (after_ack_reg == TS_READ) begin
        tx_reg       <= {rd_data[6:0], 1'b0};
        sda_oe_n_reg <= rd_data[7];
        cnt_reg      <= 4'h1;
      end else begin
        sda_oe_n_reg <= 1'b1;
      end
      state_reg <= after_ack_reg;
    end else if ((state_reg == TS_READ) && scl_fall) begin
      if (byte_full) begin
        sda_oe_n_reg <= 1'b1;
        state_reg    <= TS_SKIP;
      end else begin
        sda_oe_n_reg <= tx_reg[7];
        tx_reg       <= {tx_reg[6:0], 1'b0};
        cnt_reg      <= cnt_reg + 4'h1;
      end
    end
  end

  // ****************************************
  // Address pointer
  // ****************************************

  // Block bits come from each accepted control byte; the word address sets the low byte.
  // A repeated start leaves the pointer alone so the read phase uses it.
  always_ff @(posedge link.link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      blk_reg <= 3'h0;
      ptr_reg <= 11'h000;
    end else if (rx_state && scl_fall && byte_full && !start_det && !stop_det) begin
      if (state_reg == TS_CTRL && ctrl_hit) begin
        blk_reg <= shift_reg[3:1];
      end else if (state_reg == TS_WADDR) begin
        ptr_reg <= {blk_reg, shift_reg};
      end
    end
  end

  // ****************************************
  // Virtual output byte
  // ****************************************

  // Each bit, from virtual_output_bit_zero to virtual_output_bit_seven, drives one output.
  always_ff @(posedge link.link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      vout_reg <= `IRT_VOUT_RESET;
    end else if (vout_write) begin
      vout_reg <= shift_reg;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // The data line is only ever pulled low; the enable alone carries the bit.
  assign link.t_sda_out    = 1'b0;
  assign link.t_sda_oe_n   = sda_oe_n_reg;
  assign virtual_output_bits = vout_reg;

endmodule : irt_target

`default_nettype wire

// ===== logic/irt_master.sv
// I2C bus master controller with APB registers for byte write and random read.
`timescale 1ns/100ps
`default_nettype none

`include "irt_regs.svh"

module irt_master
  import irt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  irt_link_if.master       link
);

  localparam logic [4:0] QTR_LAST = 5'(`IRT_QTR_CYCLES - 1);

  // ****************************************
  // Declarations
  // ****************************************
  logic   [31:0] prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic   [23:0] cmd_reg;
  logic          nack_reg;
  logic          done_reg;
  irt_hst_state_t hstate_reg;
  logic    [2:0] step_reg;
  logic    [1:0] q_reg;
  logic    [4:0] tmr_reg;
  logic    [3:0] bit_reg;
  logic          rd_reg;
  logic    [7:0] rxb_reg;
  logic          ack_bad_reg;
  logic          scl_oe_n_reg;
  logic          sda_oe_n_reg;
  logic          sda_s1_reg;
  logic          sda_s2_reg;

  wire           acc;
  wire           wr_fire;
  wire           addr_hit;
  wire    [31:0] rd_mux;
  wire           go;
  wire           busy;
  wire           tick;
  wire           last_bit;
  wire    [7:0]  txbyte;
  wire    [2:0]  stop_step;
  wire           nack_set;
  wire           done_set;
  irt_kind_t     kind;

  // Kind of bus element at each step of a write or a random read.
  function automatic irt_kind_t step_kind(input logic [2:0] step, input logic rd);
    if (step == 3'h0 || (rd && step == 3'h3)) begin
      step_kind = K_START;
    end else if ((!rd && step == 3'h4) || (rd && step == 3'h6)) begin
      step_kind = K_STOP;
    end else if (rd && step == 3'h5) begin
      step_kind = K_RX;
    end else begin
      step_kind = K_TX;
    end
  endfunction : step_kind

  // Byte sent at a transmit step.
  function automatic logic [7:0] step_byte(input logic [2:0] step, input logic rd,
                                           input logic [23:0] cmd);
    if (step == 3'h1) begin
      step_byte = {cmd[`IRT_CMD_CODE_LSB +: 4], cmd[`IRT_CMD_BLK_LSB +: 3], `IRT_DIR_WRITE};
    end else if (step == 3'h2) begin
      step_byte = cmd[`IRT_CMD_WADDR_LSB +: 8];
    end else if (rd) begin
      step_byte = {cmd[`IRT_CMD_CODE_LSB +: 4], cmd[`IRT_CMD_BLK_LSB +: 3], `IRT_DIR_READ};
    end else begin
      step_byte = cmd[`IRT_CMD_WDATA_LSB +: 8];
    end
  endfunction : step_byte

  // ****************************************
  // APB slave
  // ****************************************

  // One wait state: pready rises in the second access cycle.
  assign acc      = psel & penable;
  assign wr_fire  = acc & pwrite & pready_reg;
  assign addr_hit = (paddr == `IRT_OFS_CTRL) | (paddr == `IRT_OFS_CMD) |
                    (paddr == `IRT_OFS_STATUS) | (paddr == `IRT_OFS_RDATA);
  assign busy     = (hstate_reg == HS_RUN);
  assign rd_mux   = (paddr == `IRT_OFS_CMD)    ? {8'h00, cmd_reg} :
                    (paddr == `IRT_OFS_STATUS) ? {29'h0000_0000, done_reg, nack_reg, busy} :
                    (paddr == `IRT_OFS_RDATA)  ? {24'h00_0000, rxb_reg} : 32'h0000_0000;
  assign go       = wr_fire & (paddr == `IRT_OFS_CTRL) & pwdata[`IRT_CTRL_GO_BIT] & ~busy;

  // Registers the answer so every bus output leaves a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~addr_hit;
      prdata_reg  <= (acc & ~pready_reg & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Command word is locked while a transfer runs; status flags: set wins over clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg  <= `IRT_CMD_RESET;
      nack_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (wr_fire && paddr == `IRT_OFS_CMD && !busy) begin
        cmd_reg <= pwdata[23:0];
      end
      nack_reg <= nack_set | (nack_reg & ~(wr_fire & (paddr == `IRT_OFS_STATUS) &
                                          pwdata[`IRT_STAT_NACK_BIT]));
      done_reg <= done_set | (done_reg & ~(wr_fire & (paddr == `IRT_OFS_STATUS) &
                                          pwdata[`IRT_STAT_DONE_BIT]));
    end
  end

  // ****************************************
  // Link engine
  // ****************************************
  assign tick      = busy & (tmr_reg == QTR_LAST);
  assign kind      = step_kind(step_reg, rd_reg);
  assign txbyte    = step_byte(step_reg, rd_reg, cmd_reg);
  assign last_bit  = (bit_reg == `IRT_BYTE_BITS);
  assign stop_step = rd_reg ? 3'h6 : 3'h4;
  assign nack_set  = tick & (q_reg == 2'h3) & (kind == K_TX) & last_bit & ack_bad_reg;
  assign done_set  = tick & (q_reg == 2'h3) & (kind == K_STOP);

  // Data line is sampled through two flops before the engine reads it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= link.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  // Each start, stop and bit slot is four quarter periods: set data, raise clock, sample (start and stop move data), drop clock (a stop leaves it high).
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate_reg   <= HS_IDLE;
      step_reg     <= 3'h0;
      q_reg        <= 2'h0;
      tmr_reg      <= 5'h00;
      bit_reg      <= 4'h0;
      rd_reg       <= 1'b0;
      rxb_reg      <= 8'h00;
      ack_bad_reg  <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else if (go) begin
      hstate_reg <= HS_RUN;
      step_reg   <= 3'h0;
      q_reg      <= 2'h0;
      tmr_reg    <= 5'h00;
      bit_reg    <= 4'h0;
      rd_reg     <= pwdata[`IRT_CTRL_RD_BIT];
    end else if (busy) begin
      tmr_reg <= tick ? 5'h00 : tmr_reg + 5'h01;
      if (tick) begin
        q_reg <= q_reg + 2'h1;
        unique case (q_reg)
          2'h0: begin
            if (kind == K_START) begin
              sda_oe_n_reg <= 1'b1;
            end else if (kind == K_STOP) begin
              sda_oe_n_reg <= 1'b0;
            end else begin
              sda_oe_n_reg <= (kind == K_TX && !last_bit) ? txbyte[3'(7 - bit_reg)] : 1'b1;
            end
          end
          2'h1: begin
            scl_oe_n_reg <= 1'b1;
          end
          2'h2: begin
            if (kind == K_START) begin
              sda_oe_n_reg <= 1'b0;
            end else if (kind == K_STOP) begin
              sda_oe_n_reg <= 1'b1;
            end else if (kind == K_RX && !last_bit) begin
              rxb_reg <= {rxb_reg[6:0], sda_s2_reg};
            end else if (kind == K_TX && last_bit) begin
              ack_bad_reg <= sda_s2_reg;
            end
          end
          2'h3: begin
            if (kind == K_STOP) begin
              hstate_reg <= HS_IDLE;
            end else begin
              scl_oe_n_reg <= 1'b0;
              if (kind == K_START) begin
                step_reg <= step_reg + 3'h1;
              end else if (!last_bit) begin
                bit_reg <= bit_reg + 4'h1;
              end else begin
                bit_reg  <= 4'h0;
                step_reg <= (kind == K_TX && ack_bad_reg) ? stop_step : step_reg + 3'h1;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign link.m_scl_out  = 1'b0;
  assign link.m_scl_oe_n = scl_oe_n_reg;
  assign link.m_sda_out  = 1'b0;
  assign link.m_sda_oe_n = sda_oe_n_reg;

endmodule : irt_master

`default_nettype wire

// ===== sim/irt_link_asserts.sv
// Concurrent checks on the two-wire link between the controller and the target.
`timescale 1ns/100ps
`default_nettype none

`include "irt_regs.svh"

module irt_link_asserts (
  input wire logic       link_clk,
  input wire logic       link_rst_n,
  input wire logic [3:0] cfg_code,
  input wire logic       cfg_addr_sel,
  input wire logic       m_sda_oe_n,
  input wire logic       t_sda_oe_n,
  input wire logic       scl,
  input wire logic       sda
);
  // ****
  // Bus event tracking
  // ****
  logic       scl_reg;
  logic       sda_reg;
  logic       hit_reg;
  logic       seen_reg;
  logic       dir_reg;
  logic [3:0] bit_reg;
  logic [1:0] byte_reg;
  logic [7:0] sh_reg;

  // Line events, the ninth clock of a byte and the code the target answers to.
  wire       start    = scl & scl_reg & sda_reg & ~sda;
  wire       stop     = scl & scl_reg & ~sda_reg & sda;
  wire       rise     = scl & ~scl_reg;
  wire       ack      = rise & (bit_reg == 4'h8);
  wire [3:0] exp_code = cfg_addr_sel ? cfg_code : `IRT_DEFAULT_CODE;

  // Previous line levels; idle lines are high.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
    end
  end

  // Bit and byte position since the last start; data bits shift in MSB first.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_reg  <= 4'h0;
      byte_reg <= 2'h0;
      sh_reg   <= 8'h00;
    end else if (start) begin
      bit_reg  <= 4'h0;
      byte_reg <= 2'h0;
    end else if (rise) begin
      bit_reg <= ack ? 4'h0 : bit_reg + 4'h1;
      if (!ack) sh_reg <= {sh_reg[6:0], sda};
      if (ack && byte_reg != 2'h3) byte_reg <= byte_reg + 2'h1;
    end
  end

  // Outcome of the control byte, held until the next start.
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      seen_reg <= 1'b0;
      hit_reg  <= 1'b0;
      dir_reg  <= 1'b0;
    end else if (start) begin
      seen_reg <= 1'b0;
      hit_reg  <= 1'b0;
    end else if (ack && byte_reg == 2'h0) begin
      seen_reg <= 1'b1;
      hit_reg  <= (sh_reg[7:4] == exp_code);
      dir_reg  <= sh_reg[0];
    end
  end

  // ****
  // Assertions
  // ****
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!link_rst_n);

  chk_start_hold: assert property (start |-> scl [*3])
    else $error("clock fell too soon after a start");
  chk_bus_free: assert property (stop |-> (scl && sda) [*6])
    else $error("bus not left idle after a stop");
  chk_ctrl_ack: assert property (ack && byte_reg == 2'h0 &&
      sh_reg[7:4] == exp_code |-> !t_sda_oe_n)
    else $error("matching control byte not acknowledged");
  chk_ctrl_nack: assert property (ack && byte_reg == 2'h0 &&
      sh_reg[7:4] != exp_code |-> t_sda_oe_n)
    else $error("foreign control byte acknowledged");
  chk_miss_quiet: assert property (seen_reg && !hit_reg |-> t_sda_oe_n)
    else $error("target drove data after a foreign control byte");
  chk_write_ack: assert property (ack && byte_reg inside {2'h1, 2'h2} &&
      hit_reg && !dir_reg |-> !t_sda_oe_n)
    else $error("write byte not acknowledged");
  chk_read_release: assert property (ack && byte_reg == 2'h1 &&
      hit_reg && dir_reg |-> t_sda_oe_n)
    else $error("target held data in the master acknowledge slot");
  chk_read_master_off: assert property (rise && bit_reg < 4'h8 &&
      byte_reg == 2'h1 && hit_reg && dir_reg |-> m_sda_oe_n)
    else $error("master drove data during a read byte");
  chk_sda_stable_high: assert property (scl && scl_reg |-> $stable(t_sda_oe_n))
    else $error("target changed data while the clock was high");

  cover property (ack && byte_reg == 2'h0 && hit_reg == 1'b0 && sh_reg[0]);
  cover property (seen_reg && !hit_reg && stop);
  cover property (ack && byte_reg == 2'h2 && hit_reg && !dir_reg);
endmodule : irt_link_asserts

`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the controller and target joined over the link.
`timescale 1ns/100ps
`default_nettype none

`include "irt_regs.svh"

module tb;
  typedef struct packed {
    logic       sel;
    logic [3:0] cfg;
    logic [3:0] code;
    logic [2:0] blk;
    logic [7:0] word;
    logic [7:0] wdata;
    logic       rd;
    logic       nack;
    logic [7:0] rdata;
    logic [7:0] vout;
  } irt_row_t;

  logic        pclk = 1'b0;
  logic        link_clk = 1'b0;
  logic        presetn = 1'b0;
  logic        link_rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  cfg_code = 4'h5;
  logic        cfg_addr_sel = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  vout;
  logic [31:0] d;
  logic        e;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;

  // sel, cfg, code, blk, word, wdata, rd, nack, rdata, vout.
  irt_row_t rows [8] = '{
    '{1'b0, 4'h5, 4'h1, 3'h1, 8'hDB, 8'hFF, 1'b0, 1'b0, 8'h00, 8'hFF},
    '{1'b0, 4'h5, 4'h1, 3'h1, 8'hDB, 8'h00, 1'b1, 1'b0, 8'hFF, 8'hFF},
    '{1'b1, 4'h5, 4'h5, 3'h1, 8'hDB, 8'h5A, 1'b0, 1'b0, 8'h00, 8'h5A},
    '{1'b1, 4'h5, 4'h1, 3'h1, 8'hDB, 8'hA5, 1'b0, 1'b1, 8'h00, 8'h5A},
    '{1'b0, 4'h5, 4'h5, 3'h1, 8'hDB, 8'hA5, 1'b0, 1'b1, 8'h00, 8'h5A},
    '{1'b1, 4'h5, 4'h5, 3'h0, 8'hDB, 8'h33, 1'b0, 1'b0, 8'h00, 8'h5A},
    '{1'b1, 4'h5, 4'h5, 3'h0, 8'hDB, 8'h00, 1'b1, 1'b0, 8'h00, 8'h5A},
    '{1'b1, 4'h5, 4'h5, 3'h1, 8'hDB, 8'h00, 1'b1, 1'b0, 8'h5A, 8'h5A}};

  // Both ends face each other across one link; the checker watches it.
  irt_link_if link (.link_clk(link_clk));
  irt_target irt_target_i (.link_rst_n(link_rst_n), .cfg_code(cfg_code),
    .cfg_addr_sel(cfg_addr_sel), .virtual_output_bits(vout), .link(link));
  irt_master irt_master_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  irt_link_asserts irt_link_asserts_i (.link_clk(link_clk), .link_rst_n(link_rst_n),
    .cfg_code(cfg_code), .cfg_addr_sel(cfg_addr_sel), .m_sda_oe_n(link.m_sda_oe_n),
    .t_sda_oe_n(link.t_sda_oe_n), .scl(link.scl), .sda(link.sda));

  // Bus clock, and a link clock offset so the two never align.
  always #10 pclk = ~pclk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  // Hang guard: counts as a mismatch and closes the run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      results();
    end
  end

  // ****
  // Tasks
  // ****
  task automatic results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_w

  task automatic cmp_b(input logic [7:0] got, input logic [7:0] exp);
    cmp_w({24'h00_0000, got}, {24'h00_0000, exp});
  endtask : cmp_b

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls the status word until the transfer reports done.
  task automatic wait_done(output logic [31:0] st);
    logic ee;
    int   k;
    k = 0;
    do begin
      apb(1'b0, `IRT_OFS_STATUS, 32'h0000_0000, st, ee);
      k++;
    end while (st[`IRT_STAT_DONE_BIT] !== 1'b1 && k < 3000);
  endtask : wait_done

  // One table row: command, start, completion, read byte and outputs.
  task automatic xfer(input irt_row_t r);
    cfg_addr_sel <= r.sel;
    cfg_code     <= r.cfg;
    apb(1'b1, `IRT_OFS_CMD, {8'h00, r.wdata, r.word, 1'b0, r.blk, r.code}, d, e);
    apb(1'b1, `IRT_OFS_CTRL, {30'h0000_0000, r.rd, 1'b1}, d, e);
    wait_done(d);
    cmp_w(d & 32'h0000_0007, {29'h0000_0000, 1'b1, r.nack, 1'b0});
    if (r.rd && !r.nack) begin
      apb(1'b0, `IRT_OFS_RDATA, 32'h0000_0000, d, e);
      cmp_w(d & 32'h0000_00FF, {24'h00_0000, r.rdata});
    end
    cmp_b(vout, r.vout);
    apb(1'b1, `IRT_OFS_STATUS, 32'h0000_0006, d, e);
  endtask : xfer

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (16) @(posedge pclk);
    presetn    <= 1'b1;
    link_rst_n <= 1'b1;
    repeat (8) @(posedge pclk);
    foreach (rows[i]) xfer(rows[i]);
    // A second command while busy is dropped; the byte lands in its ack slot.
    apb(1'b1, `IRT_OFS_CMD, 32'h00C3_DB15, d, e);
    apb(1'b1, `IRT_OFS_CTRL, 32'h0000_0001, d, e);
    apb(1'b1, `IRT_OFS_CMD, 32'h0011_DB15, d, e);
    apb(1'b0, `IRT_OFS_CMD, 32'h0000_0000, d, e);
    cmp_w(d, 32'h00C3_DB15);
    n = 0;
    while (vout !== 8'hC3 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    cmp_w({31'h0000_0000, link.scl}, 32'h0000_0000);
    wait_done(d);
    cmp_w(d & 32'h0000_0007, 32'h0000_0004);
    cmp_b(vout, 8'hC3);
    // Unmapped offsets answer with an error and zero data.
    apb(1'b0, 12'h010, 32'h0000_0000, d, e);
    cmp_w({d[30:0], e}, 32'h0000_0001);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF, d, e);
    cmp_w({31'h0000_0000, e}, 32'h0000_0001);
    // Reset after the last transfer has finished returns registers and outputs to their idle values.
    presetn    <= 1'b0;
    link_rst_n <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn    <= 1'b1;
    link_rst_n <= 1'b1;
    repeat (8) @(posedge pclk);
    cmp_b(vout, `IRT_VOUT_RESET);
    apb(1'b0, `IRT_OFS_CMD, 32'h0000_0000, d, e);
    cmp_w(d, 32'h0000_0000);
    apb(1'b0, `IRT_OFS_STATUS, 32'h0000_0000, d, e);
    cmp_w(d, 32'h0000_0000);
    results();
  end
endmodule : tb

`default_nettype wire
